// File: hw/id_string_rom.sv
// ascii string fields of the identify block: serial, firmware revision, model
`timescale 1ns/10ps
`include "identify_data_defines.svh"

module id_string_rom
    import identify_data_pkg::*;
#(
    // string contents are arbitrary; first character sits in the high byte of the first word
    parameter logic [`IDW_SERIAL_CHARS*8-1:0] SERIAL_TEXT = {{10{8'h20}}, "SN00000001"},
    parameter logic [`IDW_FW_CHARS*8-1:0] FW_TEXT = "REV 1.0 ",
    parameter logic [`IDW_MODEL_CHARS*8-1:0] MODEL_TEXT = {"GENERIC ATA DISK", {24{8'h20}}}
) (
    input wire word_idx_t word_idx_in,
    output id_word_t text_word_out,
    output logic text_hit_out
);

    // ----------------------------------------------------------------------
    // field slicing
    // ----------------------------------------------------------------------
    word_idx_t rel;

    always_comb begin
        rel = 8'h00;
        text_word_out = 16'h0000;
        text_hit_out = 1'b0;
        if (word_idx_in >= `IDW_W_SERIAL_FIRST && word_idx_in <= `IDW_W_SERIAL_LAST) begin
            rel = word_idx_in - `IDW_W_SERIAL_FIRST;
            text_word_out = SERIAL_TEXT[(`IDW_SERIAL_CHARS*8-1) - 16*rel -: 16];
            text_hit_out = 1'b1;
        end else if (word_idx_in >= `IDW_W_FW_FIRST && word_idx_in <= `IDW_W_FW_LAST) begin
            rel = word_idx_in - `IDW_W_FW_FIRST;
            text_word_out = FW_TEXT[(`IDW_FW_CHARS*8-1) - 16*rel -: 16];
            text_hit_out = 1'b1;
        end else if (word_idx_in >= `IDW_W_MODEL_FIRST && word_idx_in <= `IDW_W_MODEL_LAST) begin
            rel = word_idx_in - `IDW_W_MODEL_FIRST;
            text_word_out = MODEL_TEXT[(`IDW_MODEL_CHARS*8-1) - 16*rel -: 16];
            text_hit_out = 1'b1;
        end
    end

endmodule // id_string_rom

// File: hw/id_word_pointer.sv
// counter that walks the block from word 0 to word 255
`timescale 1ns/10ps
`include "identify_data_defines.svh"

module id_word_pointer
    import identify_data_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic restart_in,
    input wire logic abort_in,
    input wire logic advance_in,
    output word_idx_t word_idx_out,
    output logic [8:0] words_done_out,
    output logic running_out
);

    // ----------------------------------------------------------------------
    // transfer state and count
    // ----------------------------------------------------------------------
    xfer_state_t state_reg;
    logic [8:0] count_reg;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= xfer_idle;
        end else if (restart_in) begin
            state_reg <= xfer_run;
        end else if (abort_in) begin
            state_reg <= xfer_idle;
        end else if (state_reg == xfer_run && advance_in && count_reg == `IDW_WORD_COUNT - 9'h001) begin
            state_reg <= xfer_idle;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_reg <= 9'h000;
        end else if (restart_in) begin
            count_reg <= 9'h000;
        end else if (state_reg == xfer_run && advance_in && !abort_in) begin
            count_reg <= count_reg + 9'h001;
        end
    end

    assign word_idx_out = count_reg[7:0];
    assign words_done_out = count_reg;
    assign running_out = (state_reg == xfer_run);

endmodule // id_word_pointer

// File: hw/identify_data.sv
// identify device parameter block with its register port
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`include "identify_data_defines.svh"

// Operation
// - words 89 to 255 read zero, word 128 included
// - word 0 bit 6 set; vendor bits and bit 0 zero
// - word 0 bits 15 and 7 clear: ata device, fixed media
// - words 10-19 hold twenty serial characters, right aligned
// - words 23-26 hold eight firmware characters, left aligned
// - words 27-46 hold forty model characters, left aligned, space padded
// - word 49 bit 11 set, bit 10 clear
// - word 49 bits 9 and 8 set
// - word 49 bit 13 clear; bits 15, 14, 12 zero
// - word 51 upper byte is two
// - word 53 bit 2 set, word 88 valid
// - word 53 bits 1 and 0 set, bits 15-3 zero
// - word 88 low bits 7, current ultra dma mode in bits 10-8
module identify_data
    import identify_data_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic xfer_active_out,
    output logic xfer_done_out
);

    // ----------------------------------------------------------------------
    // word assembly helpers
    // ----------------------------------------------------------------------
    function automatic id_word_t gencfg_word();
        id_word_t w;
        w = 16'h0000;
        w[`IDW_GENCFG_ATAPI_BIT] = 1'b0;
        w[`IDW_GENCFG_REMOVABLE_BIT] = 1'b0;
        w[`IDW_GENCFG_FIXED_BIT] = 1'b1;
        return w;
    endfunction

    function automatic id_word_t caps_word();
        id_word_t w;
        w = 16'h0000;
        w[`IDW_CAPS_STANDBY_BIT] = 1'b0;
        w[`IDW_CAPS_IORDY_BIT] = 1'b1;
        w[`IDW_CAPS_IORDY_OFF_BIT] = 1'b0;
        w[`IDW_CAPS_LBA_BIT] = 1'b1;
        w[`IDW_CAPS_DMA_BIT] = 1'b1;
        return w;
    endfunction

    function automatic id_word_t valid_word();
        id_word_t w;
        w = 16'h0000;
        w[`IDW_VALID_UDMA_BIT] = 1'b1;
        w[`IDW_VALID_W64_BIT] = 1'b1;
        w[`IDW_VALID_W54_BIT] = 1'b1;
        return w;
    endfunction

    function automatic id_word_t udma_word(input udma_mode_t mode);
        id_word_t w;
        w = 16'h0000;
        w[2:0] = `IDW_UDMA_SUPPORTED;
        w[`IDW_UDMA_CUR_LSB + mode] = 1'b1;
        return w;
    endfunction

    function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    // ----------------------------------------------------------------------
    // register strobes
    // ----------------------------------------------------------------------
    logic start_wr;
    logic abort_wr;
    logic data_rd;
    logic mode_wr;

    assign start_wr = wr_in && is_reg(addr_in, `IDW_OFF_CTRL) && wdata_in[`IDW_CTRL_START_BIT];
    assign abort_wr = wr_in && is_reg(addr_in, `IDW_OFF_CTRL) && wdata_in[`IDW_CTRL_ABORT_BIT];
    assign data_rd = rd_in && is_reg(addr_in, `IDW_OFF_DATA);
    assign mode_wr = wr_in && is_reg(addr_in, `IDW_OFF_MODE);

    // ----------------------------------------------------------------------
    // word pointer and string fields
    // ----------------------------------------------------------------------
    word_idx_t word_idx;
    logic [8:0] words_done;
    logic running;
    id_word_t text_word;
    logic text_hit;

    id_word_pointer u_pointer (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .restart_in(start_wr),
        .abort_in(abort_wr),
        .advance_in(data_rd),
        .word_idx_out(word_idx),
        .words_done_out(words_done),
        .running_out(running)
    );

    id_string_rom u_strings (
        .word_idx_in(word_idx),
        .text_word_out(text_word),
        .text_hit_out(text_hit)
    );

    // ----------------------------------------------------------------------
    // current ultra dma mode
    // ----------------------------------------------------------------------
    udma_mode_t mode_reg;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_reg <= `IDW_MODE_RESET;
        end else if (mode_wr && wdata_in[1:0] <= `IDW_MODE_MAX) begin
            mode_reg <= wdata_in[1:0];
        end
    end

    // ----------------------------------------------------------------------
    // word at the pointer
    // ----------------------------------------------------------------------
    id_word_t cur_word;

    always_comb begin
        cur_word = 16'h0000;
        if (text_hit) begin
            cur_word = text_word;
        end else begin
            unique case (word_idx)
                `IDW_W_GENCFG: begin
                    cur_word = gencfg_word();
                end
                `IDW_W_CAPS: begin
                    cur_word = caps_word();
                end
                `IDW_W_PIO: begin
                    cur_word = {`IDW_PIO_MODE, 8'h00};
                end
                `IDW_W_VALID: begin
                    cur_word = valid_word();
                end
                `IDW_W_UDMA: begin
                    cur_word = udma_word(mode_reg);
                end
                default: begin
                    cur_word = 16'h0000;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // sticky flags
    // ----------------------------------------------------------------------
    logic done_reg;
    logic extra_reg;
    logic last_word;

    assign last_word = running && data_rd && words_done == `IDW_WORD_COUNT - 9'h001;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            done_reg <= 1'b0;
        end else if (last_word) begin
            done_reg <= 1'b1;
        end else if (start_wr) begin
            done_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            extra_reg <= 1'b0;
        end else if (data_rd && !running) begin
            extra_reg <= 1'b1;
        end else if (start_wr) begin
            extra_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------------
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`IDW_STAT_ACTIVE_BIT] = running;
        status_word[`IDW_STAT_DONE_BIT] = done_reg;
        status_word[`IDW_STAT_EXTRA_BIT] = extra_reg;
        status_word[`IDW_STAT_COUNT_LSB +: 9] = words_done;
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= `IDW_RDATA_RESET;
        end else if (rd_in) begin
            if (is_reg(addr_in, `IDW_OFF_DATA)) begin
                rdata_out <= running ? {16'h0000, cur_word} : 32'h0000_0000;
            end else if (is_reg(addr_in, `IDW_OFF_STATUS)) begin
                rdata_out <= status_word;
            end else if (is_reg(addr_in, `IDW_OFF_MODE)) begin
                rdata_out <= {30'h0, mode_reg};
            end else begin
                rdata_out <= 32'h0000_0000;
            end
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------------
    // status pins
    // ----------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            xfer_active_out <= 1'b0;
        end else begin
            xfer_active_out <= (running && !last_word && !abort_wr) || start_wr;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            xfer_done_out <= 1'b0;
        end else begin
            xfer_done_out <= last_word || (done_reg && !start_wr);
        end
    end

endmodule // identify_data

// File: hw/identify_data_defines.svh
// register offsets, field positions, fixed values and counts of the identify data block
`ifndef IDENTIFY_DATA_DEFINES_SVH
`define IDENTIFY_DATA_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define IDW_OFF_CTRL 8'h00
`define IDW_OFF_DATA 8'h04
`define IDW_OFF_STATUS 8'h08
`define IDW_OFF_MODE 8'h0c

// ----------------------------------------------------------------------
// register fields and reset values
// ----------------------------------------------------------------------
`define IDW_CTRL_START_BIT 0
`define IDW_CTRL_ABORT_BIT 1
`define IDW_STAT_ACTIVE_BIT 0
`define IDW_STAT_DONE_BIT 1
`define IDW_STAT_EXTRA_BIT 2
`define IDW_STAT_COUNT_LSB 16
`define IDW_MODE_RESET 2'h0
`define IDW_MODE_MAX 2'h2
`define IDW_RDATA_RESET 32'h0000_0000

// ----------------------------------------------------------------------
// word positions inside the block
// ----------------------------------------------------------------------
`define IDW_W_GENCFG 8'h00
`define IDW_W_SERIAL_FIRST 8'h0a
`define IDW_W_SERIAL_LAST 8'h13
`define IDW_W_FW_FIRST 8'h17
`define IDW_W_FW_LAST 8'h1a
`define IDW_W_MODEL_FIRST 8'h1b
`define IDW_W_MODEL_LAST 8'h2e
`define IDW_W_CAPS 8'h31
`define IDW_W_PIO 8'h33
`define IDW_W_VALID 8'h35
`define IDW_W_UDMA 8'h58
`define IDW_W_ZERO_FIRST 8'h59
`define IDW_W_SECURITY 8'h80
`define IDW_WORD_COUNT 9'h100

// ----------------------------------------------------------------------
// string field sizes in characters
// ----------------------------------------------------------------------
`define IDW_SERIAL_CHARS 20
`define IDW_FW_CHARS 8
`define IDW_MODEL_CHARS 40
`define IDW_BLANK 8'h20

// ----------------------------------------------------------------------
// bit positions and fixed values of individual words
// ----------------------------------------------------------------------
`define IDW_GENCFG_ATAPI_BIT 15
`define IDW_GENCFG_REMOVABLE_BIT 7
`define IDW_GENCFG_FIXED_BIT 6
`define IDW_CAPS_STANDBY_BIT 13
`define IDW_CAPS_IORDY_BIT 11
`define IDW_CAPS_IORDY_OFF_BIT 10
`define IDW_CAPS_LBA_BIT 9
`define IDW_CAPS_DMA_BIT 8
`define IDW_PIO_MODE 8'h02
`define IDW_VALID_UDMA_BIT 2
`define IDW_VALID_W64_BIT 1
`define IDW_VALID_W54_BIT 0
`define IDW_UDMA_SUPPORTED 3'h7
`define IDW_UDMA_CUR_LSB 8

`endif

// File: hw/identify_data_pkg.sv
// types shared by the identify data block
package identify_data_pkg;
    typedef logic [15:0] id_word_t;
    typedef logic [7:0] word_idx_t;
    typedef logic [1:0] udma_mode_t;
    typedef enum logic [0:0] {xfer_idle, xfer_run} xfer_state_t;
endpackage

// File: sim/id_host_model.sv
// host side bus master that reads the identify block
`timescale 1ns/10ps

module id_host_model (
    input wire logic sys_clk_in,
    input wire logic [31:0] rdata_in,
    output logic [7:0] addr_out,
    output logic [31:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 32'h0;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // one write cycle; released lines show the inverse
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
        #1;
    endtask
    // one read cycle; one word per data read
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge sys_clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask
endmodule // id_host_model

// File: sim/identify_data_chk.sv
// concurrent checks on the register port of the identify data block
`timescale 1ns/10ps
`include "identify_data_defines.svh"

module identify_data_chk
    import identify_data_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic xfer_active_out,
    input wire logic xfer_done_out
);
    word_idx_t idx_reg;
    logic run_reg;
    logic start_w;
    logic data_w;
    assign start_w = wr_in && addr_in == `IDW_OFF_CTRL && wdata_in[`IDW_CTRL_START_BIT];
    assign data_w = rd_in && addr_in == `IDW_OFF_DATA && run_reg;
    // ------------------------------------------------------------------
    // mirror of the word pointer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            idx_reg <= 8'h00;
        end else if (start_w) begin
            idx_reg <= 8'h00;
        end else if (data_w) begin
            idx_reg <= idx_reg + 8'h01;
        end
    end
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_reg <= 1'b0;
        end else if (start_w) begin
            run_reg <= 1'b1;
        end else if (wr_in && addr_in == `IDW_OFF_CTRL && wdata_in[`IDW_CTRL_ABORT_BIT]) begin
            run_reg <= 1'b0;
        end else if (data_w && idx_reg == 8'hff) begin
            run_reg <= 1'b0;
        end
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence word_rd_s(logic [7:0] n);
        data_w && idx_reg == n;
    endsequence
    sequence text_rd_s;
        data_w && ((idx_reg >= 8'h0a && idx_reg <= 8'h13) || (idx_reg >= 8'h17 && idx_reg <= 8'h2e));
    endsequence
    gencfg_word_a: assert property (word_rd_s(`IDW_W_GENCFG) |=> rdata_out == 32'h0000_0040)
        else $error("general configuration word wrong");
    caps_word_a: assert property (word_rd_s(`IDW_W_CAPS) |=> rdata_out[31:8] == 24'h00_000b)
        else $error("capability word wrong");
    pio_word_a: assert property (word_rd_s(`IDW_W_PIO) |=> rdata_out[31:8] == 24'h00_0002)
        else $error("pio mode word wrong");
    valid_word_a: assert property (word_rd_s(`IDW_W_VALID) |=> rdata_out == 32'h0000_0007)
        else $error("field validity word wrong");
    udma_word_a: assert property (word_rd_s(`IDW_W_UDMA) |=> rdata_out[7:0] == 8'h07 && rdata_out[31:11] == 21'h0 && $onehot(rdata_out[10:8]))
        else $error("ultra dma word wrong");
    zero_tail_a: assert property (data_w && idx_reg >= `IDW_W_ZERO_FIRST |=> rdata_out == 32'h0)
        else $error("reserved word not zero");
    text_ascii_a: assert property (text_rd_s |=> rdata_out[31:16] == 16'h0000 && rdata_out[15:8] inside {[8'h20:8'h7e]} && rdata_out[7:0] inside {[8'h20:8'h7e]})
        else $error("string word not printable");
    last_word_a: assert property (word_rd_s(8'hff) |=> xfer_done_out && !xfer_active_out)
        else $error("transfer not finished after last word");
    start_run_a: assert property (start_w |=> xfer_active_out && !xfer_done_out)
        else $error("start did not begin transfer");
    quiet_read_a: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data outside answer cycle");
endmodule // identify_data_chk

bind identify_data identify_data_chk identify_data_chk_i (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .xfer_active_out(xfer_active_out), .xfer_done_out(xfer_done_out));

// File: sim/tb_identify_data.sv
// self-checking bench for the identify data block
`timescale 1ns/10ps
`include "identify_data_defines.svh"

module tb_identify_data;
    import identify_data_pkg::*;
    logic sys_clk_in;
    logic rstn_in;
    logic [7:0] addr_in;
    logic [31:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic [31:0] rdata_out;
    logic xfer_active_out;
    logic xfer_done_out;
    logic [31:0] d;
    logic [31:0] seed;
    logic [1:0] mode;
    int n_fail;
    int checked;
    int cyc;
    int k;

    identify_data identify_data_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .xfer_active_out(xfer_active_out), .xfer_done_out(xfer_done_out));
    id_host_model id_host_model_i (.sys_clk_in(sys_clk_in), .rdata_in(rdata_out), .addr_out(addr_in),
        .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));

    initial sys_clk_in = 1'b0;
    always #10 sys_clk_in = ~sys_clk_in;

    // ------------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------------
    function automatic logic [15:0] exp_word(input int i, input logic [1:0] m);
        logic [159:0] sn;
        logic [63:0] fw;
        logic [319:0] md;
        sn = {{10{8'h20}}, "SN00000001"};
        fw = "REV 1.0 ";
        md = {"GENERIC ATA DISK", {24{8'h20}}};
        if (i == 0) return 16'h0040;
        if (i >= 10 && i <= 19) return sn[159-16*(i-10) -: 16];
        if (i >= 23 && i <= 26) return fw[63-16*(i-23) -: 16];
        if (i >= 27 && i <= 46) return md[319-16*(i-27) -: 16];
        if (i == 49) return 16'h0b00;
        if (i == 51) return 16'h0200;
        if (i == 53) return 16'h0007;
        if (i == 88) return 16'h0007 | (16'h0100 << m);
        return 16'h0000;
    endfunction
    function automatic logic [31:0] exp_stat(input int n, input logic ex);
        return {7'h0, 9'(n), 13'h0, ex, n == 256, n != 256};
    endfunction

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'ha418;
        n_fail = 0;
        checked = 0;
        cyc = 0;
        mode = 2'h0;
        rstn_in = 1'b0;
        repeat (16) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        @(posedge sys_clk_in);
        id_host_model_i.bus_read(`IDW_OFF_DATA, d);
        chk32(d, 32'h0);
        id_host_model_i.bus_read(`IDW_OFF_STATUS, d);
        chk32(d, exp_stat(0, 1'b1) & 32'hffff_fffe);
        id_host_model_i.bus_write(8'h20, $random(seed));
        id_host_model_i.bus_read(8'h20, d);
        chk32(d, 32'h0);
        for (int p = 0; p < 4; p++) begin
            id_host_model_i.bus_write(`IDW_OFF_MODE, {30'h0, 2'(p)});
            if (p != 3) mode = 2'(p);
            id_host_model_i.bus_read(`IDW_OFF_MODE, d);
            chk32(d, {30'h0, mode});
            // partial transfer, then abort or restart in mid-run
            id_host_model_i.bus_write(`IDW_OFF_CTRL, 32'h1);
            k = $random(seed) & 7;
            for (int i = 0; i < k; i++) begin
                id_host_model_i.bus_read(`IDW_OFF_DATA, d);
                chk32(d, {16'h0, exp_word(i, mode)});
            end
            id_host_model_i.bus_write(`IDW_OFF_CTRL, (p == 1) ? 32'h2 : 32'h3);
            chk1(xfer_active_out, p != 1);
            if (p == 1) id_host_model_i.bus_write(`IDW_OFF_CTRL, 32'h1);
            for (int i = 0; i < 256; i++) begin
                id_host_model_i.bus_read(`IDW_OFF_DATA, d);
                chk32(d, {16'h0, exp_word(i, mode)});
                if (($random(seed) & 15) == 0) begin
                    id_host_model_i.bus_read(`IDW_OFF_STATUS, d);
                    chk32(d, exp_stat(i + 1, 1'b0));
                end
                repeat ($random(seed) & 3) @(posedge sys_clk_in);
            end
            chk1(xfer_done_out, 1'b1);
            chk1(xfer_active_out, 1'b0);
            id_host_model_i.bus_read(`IDW_OFF_DATA, d);
            chk32(d, 32'h0);
            id_host_model_i.bus_read(`IDW_OFF_STATUS, d);
            chk32(d, exp_stat(256, 1'b1));
        end
        end_of_test();
    end
endmodule // tb_identify_data
